//--- aodc_pkg.sv
/*
 * Package for the auxiliary output driver control block: register offsets,
 * field positions, reset values and timing constants.
 * Assumes a 100 MHz system clock and a 32-bit classic Wishbone register bus.
 */
package aodc_pkg;

    // ************************************************************
    // Register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] AODC_ADR_IMP_CTRL  = 8'h00;
    localparam logic [7:0] AODC_ADR_RLY_CTRL  = 8'h04;
    localparam logic [7:0] AODC_ADR_LED_CTRL  = 8'h08;
    localparam logic [7:0] AODC_ADR_DET_CTRL  = 8'h0C;
    localparam logic [7:0] AODC_ADR_SENSE     = 8'h10;
    localparam logic [7:0] AODC_ADR_IRQ_STAT  = 8'h14;
    localparam logic [7:0] AODC_ADR_IRQ_EN    = 8'h18;
    localparam logic [7:0] AODC_ADR_IRQ_CLR   = 8'h1C;

    // ************************************************************
    // Field positions
    // ************************************************************
    // Impedance control
    localparam int AODC_IMP_MEN      = 0;
    localparam int AODC_IMP_PAIR_LSB = 1;
    localparam int AODC_IMP_RAIL_SEL = 4;
    localparam int AODC_IMP_BYPASS   = 5;
    localparam int AODC_IMP_SLP_OFF  = 6;
    localparam int AODC_IMP_PAIRS    = 3;
    // Relay control
    localparam int AODC_RLY_EN       = 0;
    localparam int AODC_RLY_ASSERT   = 1;
    localparam int AODC_RLY_SLP_KEEP = 2;
    localparam int AODC_RLY_DUTY_LSB = 8;
    localparam int AODC_RLY_DUTY_W   = 8;
    // LED control, one byte per LED starting at these positions
    localparam int AODC_LED_EN       = 0;
    localparam int AODC_LED_CUR_LSB  = 1;
    localparam int AODC_LED_CUR_W    = 4;
    localparam int AODC_LED_PAT_LSB  = 5;
    localparam int AODC_LED_PAT_W    = 3;
    localparam int AODC_LED_STRIDE   = 8;
    localparam int AODC_LED_SLP_KEEP = 16;
    // Charger detection control
    localparam int AODC_DET_MODE     = 0;
    localparam int AODC_DET_SRC_EN   = 1;
    localparam int AODC_DET_SRC_PIN  = 2;
    localparam int AODC_DET_SNK_EN   = 3;
    localparam int AODC_DET_SNK_PIN  = 4;
    localparam int AODC_DET_CMP_EN   = 5;
    localparam int AODC_DET_CMP_PIN  = 6;
    // Sense / interrupt status bits
    localparam int AODC_EV_RLY_OPEN  = 0;
    localparam int AODC_EV_LED1      = 1;
    localparam int AODC_EV_LED2      = 2;
    localparam int AODC_EV_W         = 3;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [31:0] AODC_RST_ZERO  = 32'h0000_0000;
    localparam logic [7:0]  AODC_RST_DUTY  = 8'h80;
    localparam logic [7:0]  AODC_DUTY_FULL = 8'hFF;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int AODC_CLK_HZ       = 100_000_000;
    localparam int AODC_TPU_US       = 20_000;
    localparam int AODC_TPU_CYC      = (AODC_TPU_US / 1_000_000.0 > 0) ?
                                       AODC_TPU_US * (AODC_CLK_HZ / 1_000_000) : 1;
    localparam int AODC_PWM_DIV      = 4;
    localparam int AODC_BLINK_DIV    = 4096;
    localparam int AODC_CNT_W        = 24;

endpackage

//--- aodc_divider.sv
/*
 * Enable-pulse divider: a one-cycle tick every DIV cycles of the selected
 * source. Assumes one clock; the source enable selects which ticks count.
 */
`timescale 1ns/1ns
module aodc_divider #(
    parameter int DIV = 4
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic src_en_i,
    output logic      tick_o
);
    logic [15:0] cnt_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r  <= 16'h0000;
            tick_o <= 1'b0;
        end else if (src_en_i) begin
            if (cnt_r == 16'(DIV - 1)) begin
                cnt_r  <= 16'h0000;
                tick_o <= 1'b1;
            end else begin
                cnt_r  <= cnt_r + 16'h0001;
                tick_o <= 1'b0;
            end
        end else begin
            tick_o <= 1'b0;
        end
    end
endmodule // aodc_divider

//--- aodc_top.sv
/*
 * Auxiliary output driver control: impedance drivers, relay driver with
 * PWM hold, two LED drivers with blink and faults, charger detection front
 * end, sticky interrupts, classic Wishbone slave.
 * Assumes analog sense inputs already synchronous to clk_i; the crystal and
 * on-chip oscillator ticks arrive as enable pulses on clk_i.
 */
`timescale 1ns/1ns

// Function
// - Three impedance drive outputs, each with its own enable bit.
// - Rail select picks negative pump or ground; bypass option in either case.
// - After reset or master enable low: drivers, pump off, outputs pulled low.
// - With pump on, each output follows its own pair enable.
// - Optional automatic shutdown of impedance drivers and pump in sleep.
// - Relay fully on for pick-up delay, then programmable duty PWM.
// - Full-scale duty keeps relay continuously on.
// - Relay PWM ticks from crystal clock, else on-chip oscillator.
// - No coil current while relay active raises interrupt.
// - Relay disabled at reset; sleep option keeps or disables it.
// - LED open or short raises interrupt; driver stays enabled.
// - Each LED has its own current setting.
// - Per-LED blink patterns from on-chip oscillator, phase-synchronous.
// - LEDs off and high impedance after reset; sleep option disables or keeps.
// - Detection mode: one source, sink, comparator, register-assigned to pins.
// - Detection comparator reported on the LED fault sense and interrupt bit.
module aodc_top
    import aodc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // System status
    input  wire logic        sleep_i,
    input  wire logic        xtal_ok_i,
    input  wire logic        xtal_tick_i,
    input  wire logic        osc_tick_i,
    input  wire logic        coil_current_i,
    input  wire logic [1:0]  led_fault_i,
    input  wire logic        detect_compare_i,
    // Impedance drivers
    output logic             charge_pump_en_o,
    output logic [2:0]       impedance_drive_out_o,
    output logic [2:0]       impedance_pulldown_o,
    output logic             impedance_low_rail_neg_o,
    output logic             impedance_bypass_o,
    // Relay
    output logic             relay_drive_out_o,
    // LED / detection pins
    output logic [1:0]       led_drive_o,
    output logic [1:0]       led_oe_n_o,
    output logic [7:0]       led_current_o,
    output logic             detect_voltage_source_en_o,
    output logic             detect_voltage_source_pin_o,
    output logic             detect_current_sink_en_o,
    output logic             detect_current_sink_pin_o,
    output logic             detect_compare_reference_en_o,
    output logic             detect_compare_pin_o,
    output logic             irq_o
);

    // ************************************************************
    // Registers
    // ************************************************************
    logic [31:0]          imp_ctrl_r;
    logic [31:0]          rly_ctrl_r;
    logic [31:0]          led_ctrl_r;
    logic [31:0]          det_ctrl_r;
    logic [AODC_EV_W-1:0] irq_stat_r;
    logic [AODC_EV_W-1:0] irq_en_r;
    logic [AODC_EV_W-1:0] sense_r;
    logic [AODC_EV_W-1:0] clr_pulse;
    logic                 wr_en;
    logic                 rd_en;

    assign wr_en = cyc_i && stb_i && we_i && !ack_o;
    assign rd_en = cyc_i && stb_i && !we_i && !ack_o;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return res;
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            imp_ctrl_r <= AODC_RST_ZERO;
            rly_ctrl_r <= {16'h0000, AODC_RST_DUTY, 8'h00};
            led_ctrl_r <= AODC_RST_ZERO;
            det_ctrl_r <= AODC_RST_ZERO;
            irq_en_r   <= '0;
        end else if (wr_en) begin
            case (adr_i)
                AODC_ADR_IMP_CTRL: imp_ctrl_r <= merge(imp_ctrl_r, dat_i, sel_i);
                AODC_ADR_RLY_CTRL: rly_ctrl_r <= merge(rly_ctrl_r, dat_i, sel_i);
                AODC_ADR_LED_CTRL: led_ctrl_r <= merge(led_ctrl_r, dat_i, sel_i);
                AODC_ADR_DET_CTRL: det_ctrl_r <= merge(det_ctrl_r, dat_i, sel_i);
                AODC_ADR_IRQ_EN:   irq_en_r   <= sel_i[0] ? dat_i[AODC_EV_W-1:0] : irq_en_r;
                default: begin
                end
            endcase
        end
    end

    assign clr_pulse = (wr_en && adr_i == AODC_ADR_IRQ_CLR && sel_i[0]) ?
                       dat_i[AODC_EV_W-1:0] : '0;

    // Bus answer one cycle after the request; unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= AODC_RST_ZERO;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
            if (rd_en) begin
                case (adr_i)
                    AODC_ADR_IMP_CTRL: dat_o <= imp_ctrl_r;
                    AODC_ADR_RLY_CTRL: dat_o <= rly_ctrl_r;
                    AODC_ADR_LED_CTRL: dat_o <= led_ctrl_r;
                    AODC_ADR_DET_CTRL: dat_o <= det_ctrl_r;
                    AODC_ADR_SENSE:    dat_o <= {29'h0, sense_r};
                    AODC_ADR_IRQ_STAT: dat_o <= {29'h0, irq_stat_r};
                    AODC_ADR_IRQ_EN:   dat_o <= {29'h0, irq_en_r};
                    default:           dat_o <= AODC_RST_ZERO;
                endcase
            end
        end
    end

    // ************************************************************
    // Impedance drivers
    // ************************************************************
    logic imp_run;
    // Rail and bypass settings are only sampled, never guarded; software keeps them still while running
    assign imp_run = imp_ctrl_r[AODC_IMP_MEN] && !(sleep_i && imp_ctrl_r[AODC_IMP_SLP_OFF]);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            charge_pump_en_o         <= 1'b0;
            impedance_drive_out_o    <= 3'h0;
            impedance_pulldown_o     <= 3'h7;
            impedance_low_rail_neg_o <= 1'b0;
            impedance_bypass_o       <= 1'b0;
        end else begin
            charge_pump_en_o         <= imp_run;
            impedance_low_rail_neg_o <= imp_ctrl_r[AODC_IMP_RAIL_SEL];
            impedance_bypass_o       <= imp_ctrl_r[AODC_IMP_BYPASS];
            for (int i = 0; i < AODC_IMP_PAIRS; i++) begin
                impedance_drive_out_o[i] <= imp_run && imp_ctrl_r[AODC_IMP_PAIR_LSB + i];
                impedance_pulldown_o[i]  <= !imp_run;
            end
        end
    end

    // ************************************************************
    // Relay driver
    // ************************************************************
    typedef enum logic [2:0] {
        AODC_RLY_OFF  = 3'b001,
        AODC_RLY_PICK = 3'b010,
        AODC_RLY_HOLD = 3'b100
    } aodc_rly_state_t;

    aodc_rly_state_t     rly_state_r;
    logic [AODC_CNT_W-1:0] pu_cnt_r;
    logic [7:0]          pwm_cnt_r;
    logic                pwm_tick;
    logic                rly_active;
    logic                rly_on_nxt;
    logic [7:0]          duty;

    assign duty       = rly_ctrl_r[AODC_RLY_DUTY_LSB +: AODC_RLY_DUTY_W];
    assign rly_active = rly_ctrl_r[AODC_RLY_EN] && rly_ctrl_r[AODC_RLY_ASSERT] &&
                        !(sleep_i && !rly_ctrl_r[AODC_RLY_SLP_KEEP]);

    // Crystal ticks preferred; on-chip oscillator keeps the hold alive without it
    aodc_divider #(
        .DIV      (AODC_PWM_DIV)
    ) u_pwm_div (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .src_en_i (xtal_ok_i ? xtal_tick_i : osc_tick_i),
        .tick_o   (pwm_tick)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rly_state_r <= AODC_RLY_OFF;
            pu_cnt_r    <= '0;
        end else begin
            case (rly_state_r)
                AODC_RLY_OFF: begin
                    pu_cnt_r <= '0;
                    if (rly_active) begin
                        rly_state_r <= AODC_RLY_PICK;
                    end
                end
                AODC_RLY_PICK: begin
                    if (!rly_active) begin
                        rly_state_r <= AODC_RLY_OFF;
                    end else if (pu_cnt_r == AODC_CNT_W'(AODC_TPU_CYC - 1)) begin
                        rly_state_r <= AODC_RLY_HOLD;
                    end else begin
                        pu_cnt_r <= pu_cnt_r + 1'b1;
                    end
                end
                AODC_RLY_HOLD: begin
                    if (!rly_active) begin
                        rly_state_r <= AODC_RLY_OFF;
                    end
                end
                default: rly_state_r <= AODC_RLY_OFF;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwm_cnt_r <= 8'h00;
        end else if (pwm_tick) begin
            pwm_cnt_r <= (pwm_cnt_r == AODC_DUTY_FULL - 8'h01) ? 8'h00 : pwm_cnt_r + 8'h01;
        end
    end

    always_comb begin
        case (rly_state_r)
            AODC_RLY_PICK: rly_on_nxt = 1'b1;
            AODC_RLY_HOLD: rly_on_nxt = (duty == AODC_DUTY_FULL) || (pwm_cnt_r < duty);
            default:       rly_on_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            relay_drive_out_o <= 1'b0;
        end else begin
            relay_drive_out_o <= rly_on_nxt;
        end
    end

    // ************************************************************
    // LED drivers and charger detection
    // ************************************************************
    logic        blink_tick;
    logic [7:0]  blink_cnt_r;
    logic        det_mode;
    logic        led_keep;
    logic [1:0]  led_fault_sense;

    assign det_mode = det_ctrl_r[AODC_DET_MODE];
    assign led_keep = !sleep_i || led_ctrl_r[AODC_LED_SLP_KEEP];

    aodc_divider #(
        .DIV      (AODC_BLINK_DIV)
    ) u_blink_div (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .src_en_i (osc_tick_i),
        .tick_o   (blink_tick)
    );

    // One shared phase counter keeps both patterns locked together
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            blink_cnt_r <= 8'h00;
        end else if (blink_tick) begin
            blink_cnt_r <= blink_cnt_r + 8'h01;
        end
    end

    // Pattern: 0 steady, 1..7 on for one phase step every 2^pattern steps
    function automatic logic blink_on(input logic [2:0] pat, input logic [7:0] ph);
        logic [7:0] mask;
        mask = (8'h01 << pat) - 8'h01;
        return (pat == 3'h0) || ((ph & mask) == 8'h00);
    endfunction

    generate
        for (genvar g = 0; g < 2; g++) begin : g_led
            logic       en;
            logic [2:0] pat;
            assign en  = led_ctrl_r[g*AODC_LED_STRIDE + AODC_LED_EN];
            assign pat = led_ctrl_r[g*AODC_LED_STRIDE + AODC_LED_PAT_LSB +: AODC_LED_PAT_W];
            // Fault is reported only; the driver stays under software control
            assign led_fault_sense[g] = en && led_fault_i[g];

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    led_drive_o[g]             <= 1'b0;
                    led_oe_n_o[g]              <= 1'b1;
                    led_current_o[g*4 +: 4]    <= 4'h0;
                end else begin
                    led_drive_o[g]             <= !det_mode && en && led_keep && blink_on(pat, blink_cnt_r);
                    led_oe_n_o[g]              <= !(!det_mode && en && led_keep);
                    led_current_o[g*4 +: 4]    <=
                        led_ctrl_r[g*AODC_LED_STRIDE + AODC_LED_CUR_LSB +: AODC_LED_CUR_W];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            detect_voltage_source_en_o    <= 1'b0;
            detect_voltage_source_pin_o   <= 1'b0;
            detect_current_sink_en_o      <= 1'b0;
            detect_current_sink_pin_o     <= 1'b0;
            detect_compare_reference_en_o <= 1'b0;
            detect_compare_pin_o          <= 1'b0;
        end else begin
            detect_voltage_source_en_o    <= det_mode && det_ctrl_r[AODC_DET_SRC_EN];
            detect_voltage_source_pin_o   <= det_ctrl_r[AODC_DET_SRC_PIN];
            detect_current_sink_en_o      <= det_mode && det_ctrl_r[AODC_DET_SNK_EN];
            detect_current_sink_pin_o     <= det_ctrl_r[AODC_DET_SNK_PIN];
            detect_compare_reference_en_o <= det_mode && det_ctrl_r[AODC_DET_CMP_EN];
            detect_compare_pin_o          <= det_ctrl_r[AODC_DET_CMP_PIN];
        end
    end

    // ************************************************************
    // Sense and interrupts
    // ************************************************************
    logic [AODC_EV_W-1:0] sense_nxt;
    logic                 cmp_live;

    assign cmp_live = det_mode && det_ctrl_r[AODC_DET_CMP_EN] && detect_compare_i;

    always_comb begin
        sense_nxt                   = '0;
        sense_nxt[AODC_EV_RLY_OPEN] = (rly_state_r != AODC_RLY_OFF) && !coil_current_i;
        // The comparator shares the fault bit of the pin it watches; software reads the result
        sense_nxt[AODC_EV_LED1]     = det_mode ? (cmp_live && !det_ctrl_r[AODC_DET_CMP_PIN])
                                               : led_fault_sense[0];
        sense_nxt[AODC_EV_LED2]     = det_mode ? (cmp_live && det_ctrl_r[AODC_DET_CMP_PIN])
                                               : led_fault_sense[1];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sense_r    <= '0;
            irq_stat_r <= '0;
            irq_o      <= 1'b0;
        end else begin
            sense_r    <= sense_nxt;
            // Set wins over a clear in the same cycle
            irq_stat_r <= (irq_stat_r & ~clr_pulse) | sense_nxt;
            irq_o      <= |(((irq_stat_r & ~clr_pulse) | sense_nxt) & irq_en_r);
        end
    end

endmodule // aodc_top

//--- aodc_top_monitor.sv
/* Checker for aodc_top: bus answer, reset values, driver and interrupt relations.
   Assumes it is bound to aodc_top and sees only its ports, one clock domain. */
`timescale 1ns/1ns
module aodc_top_monitor (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic        ack_o,
    input wire logic [31:0] dat_o,
    input wire logic        charge_pump_en_o,
    input wire logic [2:0]  impedance_drive_out_o,
    input wire logic [2:0]  impedance_pulldown_o,
    input wire logic        relay_drive_out_o,
    input wire logic [1:0]  led_drive_o,
    input wire logic [1:0]  led_oe_n_o,
    input wire logic        irq_o
);
    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_answer; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("ack missing");
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_idle; !(cyc_i && stb_i) |=> !ack_o; endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("ack without request");
    property p_dat_hold; !ack_o |-> $stable(dat_o); endproperty
    a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
    property p_reset_vals; $past(rst_i) |-> !irq_o && !relay_drive_out_o && !charge_pump_en_o
        && led_oe_n_o == 2'h3 && led_drive_o == 2'h0 && impedance_pulldown_o == 3'h7; endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset value");
    property p_pump_off; !charge_pump_en_o |-> impedance_drive_out_o == 3'h0 && impedance_pulldown_o == 3'h7; endproperty
    a_pump_off: assert property (p_pump_off) else $error("driver not parked");
    property p_pump_on; charge_pump_en_o |-> impedance_pulldown_o == 3'h0; endproperty
    a_pump_on: assert property (p_pump_on) else $error("pulldown while driving");
    property p_led_oe; (led_drive_o & led_oe_n_o) == 2'h0; endproperty
    a_led_oe: assert property (p_led_oe) else $error("led on while high-Z");
    // A clear write drops irq_o at the edge that raises its ack; an enable write drops it one cycle later, where ack is already sampled low again
    property p_irq_sticky; $fell(irq_o) |-> ack_o && we_i; endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("irq dropped alone");
endmodule // aodc_top_monitor

//--- aodc_top_tb_top.sv
/* Testbench for aodc_top: Wishbone master tasks, queued read checks, output checks.
   Assumes the aodc_pkg register map and one 100 MHz clock. */
`timescale 1ns/1ns
`define CK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
module aodc_top_tb_top;
    import aodc_pkg::*;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, sleep_i, xtal_ok_i, xtal_tick_i, osc_tick_i, coil_current_i;
    logic        detect_compare_i, ack_o, irq_o, charge_pump_en_o, impedance_low_rail_neg_o, impedance_bypass_o;
    logic        relay_drive_out_o, detect_voltage_source_en_o, detect_voltage_source_pin_o, detect_compare_pin_o;
    logic        detect_current_sink_en_o, detect_current_sink_pin_o, detect_compare_reference_en_o;
    logic [1:0]  led_fault_i, led_drive_o, led_oe_n_o;
    logic [2:0]  impedance_drive_out_o, impedance_pulldown_o;
    logic [3:0]  sel_i, c1, c2;
    logic [7:0]  adr_i, led_current_o;
    logic [31:0] dat_i, dat_o, cfg, e, exp_q[$];
    int          fails, check_count;
    wire  [5:0]  det_v = {detect_voltage_source_en_o, detect_voltage_source_pin_o, detect_current_sink_en_o,
                          detect_current_sink_pin_o, detect_compare_reference_en_o, detect_compare_pin_o};
    aodc_top dut (.*);
    initial begin
        clk_i = 0;
        forever #5 clk_i = ~clk_i;
    end
    // Oscillator ticks run free so relay and blink timing never stall
    always @(posedge clk_i) begin
        xtal_tick_i <= 1'($urandom);
        osc_tick_i  <= 1'($urandom);
    end
    // ************************************************************
    // Read watcher: oldest expected value against each read answer
    // ************************************************************
    always @(posedge clk_i) if (ack_o === 1'b1 && we_i === 1'b0) begin
        e = exp_q.pop_front();
        `CK("dat_o", e, dat_o)
    end
    task close_out;
        if (fails == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (ack_o !== 1'b1) begin
            fails++;
            close_out;
        end
        cyc_i <= 0;
        stb_i <= 0;
        we_i <= 0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x);
        exp_q.push_back(x);
        wb(0, a, 0);
    endtask
    task w(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        void'($urandom(32'h6457BF17));
        // Coil current present and awake at start, so the open-coil event only comes when the bench drops it
        {rst_i, cyc_i, stb_i, we_i, sleep_i, coil_current_i, detect_compare_i} = 7'h42;
        {xtal_ok_i, led_fault_i, adr_i, sel_i, dat_i} = {1'b1, 2'h0, 8'h00, 4'hF, 32'h0};
        fails = 0;
        check_count = 0;
        repeat (3) @(posedge clk_i);
        rst_i <= 0;
        for (int i = 0; i < 9; i++) rd(8'(i * 4), (i == 1) ? {16'h0, AODC_RST_DUTY, 8'h0} : 32'h0);
        for (int i = 0; i < 4; i++) begin
            cfg = $urandom & 32'h3E;
            wb(1, AODC_ADR_IMP_CTRL, 0);
            wb(1, AODC_ADR_IMP_CTRL, cfg);
            wb(1, AODC_ADR_IMP_CTRL, cfg | 1);
            w(2);
            `CK("pump", 1'b1, charge_pump_en_o)
            `CK("drive", cfg[3:1], impedance_drive_out_o)
            `CK("rail", cfg[5:4], {impedance_bypass_o, impedance_low_rail_neg_o})
        end
        wb(1, AODC_ADR_IMP_CTRL, 32'h41);
        @(posedge clk_i) sleep_i <= 1;
        w(3);
        `CK("pump", 1'b0, charge_pump_en_o)
        @(posedge clk_i) sleep_i <= 0;
        wb(1, AODC_ADR_IRQ_EN, 32'h7);
        wb(1, AODC_ADR_RLY_CTRL, 32'h8003);
        w(2);
        `CK("relay", 1'b1, relay_drive_out_o)
        `CK("irq", 1'b0, irq_o)
        @(posedge clk_i) coil_current_i <= 0;
        w(3);
        `CK("irq", 1'b1, irq_o)
        @(posedge clk_i) coil_current_i <= 1;
        rd(AODC_ADR_SENSE, 0);
        rd(AODC_ADR_IRQ_STAT, 1);
        wb(1, AODC_ADR_IRQ_CLR, 1);
        w(2);
        `CK("irq", 1'b0, irq_o)
        @(posedge clk_i) sleep_i <= 1;
        w(3);
        `CK("relay", 1'b0, relay_drive_out_o)
        @(posedge clk_i) sleep_i <= 0;
        wb(1, AODC_ADR_RLY_CTRL, 32'h8000);
        c1 = 4'($urandom);
        c2 = 4'($urandom);
        wb(1, AODC_ADR_LED_CTRL, {16'h0, 3'h0, c2, 1'b1, 3'h0, c1, 1'b1});
        w(2);
        `CK("cur", {c2, c1}, led_current_o)
        `CK("oe_n", 2'h0, led_oe_n_o)
        wb(1, AODC_ADR_IRQ_EN, 0);
        @(posedge clk_i) led_fault_i <= 2'h2;
        w(3);
        `CK("irq", 1'b0, irq_o)
        `CK("led", 2'h3, led_drive_o)
        @(posedge clk_i) led_fault_i <= 0;
        rd(AODC_ADR_IRQ_STAT, 4);
        wb(1, AODC_ADR_IRQ_EN, 4);
        w(2);
        `CK("irq", 1'b1, irq_o)
        wb(1, AODC_ADR_IRQ_CLR, 7);
        @(posedge clk_i) sleep_i <= 1;
        w(3);
        `CK("led", 2'h0, led_drive_o)
        @(posedge clk_i) sleep_i <= 0;
        for (int i = 0; i < 2; i++) begin
            cfg = i ? 32'h2F : 32'h7B;
            wb(1, AODC_ADR_DET_CTRL, cfg);
            w(2);
            `CK("det", {cfg[1], cfg[2], cfg[3], cfg[4], cfg[5], cfg[6]}, det_v)
            @(posedge clk_i) detect_compare_i <= 1;
            rd(AODC_ADR_SENSE, cfg[6] ? 4 : 2);
            @(posedge clk_i) detect_compare_i <= 0;
        end
        w(4);
        close_out;
    end
endmodule // aodc_top_tb_top
bind aodc_top aodc_top_monitor mon (.*);
